// [logic/apf_pkg.sv]
// Shared constants for the amplifier protection and fault control block
package apf_pkg;
  // PWM carrier geometry
  localparam int          PWM_BITS      = 8;
  localparam int          PWM_PERIOD    = 256;
  localparam logic [8:0]  PWM_HALF      = 9'h080;
  localparam int          LIMIT_SCALE   = 4;
  localparam int          SAMPLE_BITS   = 16;
  // Clock rate and persistence time of a DC imbalance
  localparam int          CLK_KHZ       = 250000;
  localparam int          DC_TIME_MS    = 420;
  localparam int          DC_PERSIST_CYC = DC_TIME_MS * CLK_KHZ;
  // Differential duty imbalance that counts as DC, in percent
  localparam int          DC_PCT        = 14;
  // Die temperature trip point and recovery drop, degrees C
  localparam logic [7:0]  TEMP_TRIP_C   = 8'h96;
  localparam logic [7:0]  TEMP_HYST_C   = 8'h0f;
  // Register byte offsets
  localparam logic [7:0]  ADDR_LIMIT    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  // Reset values
  localparam logic [7:0]  LIMIT_RST     = 8'hff;
  localparam logic        CTRL_RST      = 1'b0;
  // Status field positions
  localparam int          ST_DC         = 0;
  localparam int          ST_SHORT      = 1;
  localparam int          ST_THERM      = 2;
  localparam int          ST_SHDN_N     = 3;
  localparam int          ST_PAR        = 4;
  localparam int          ST_GAIN       = 5;
  localparam int          ST_RUN        = 7;
  // Pin synchroniser lanes
  localparam int          SY_SHDN       = 0;
  localparam int          SY_PAR        = 1;
  localparam int          SY_G0         = 2;
  localparam int          SY_G1         = 3;
  localparam int          SY_OC         = 4;
  localparam int          SY_W          = 8;
endpackage

// [logic/apf_pwm_bridge.sv]
// One H-bridge: compares the shared carrier against both duty values
`timescale 1ns/1ps
module apf_pwm_bridge
  import apf_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Carrier and duties
  input  wire logic [PWM_BITS-1:0] carrier,
  input  wire logic                run,
  input  wire logic [PWM_BITS:0]   duty_p,
  input  wire logic [PWM_BITS:0]   duty_n,
  // Switching levels
  output logic                     out_p,
  output logic                     out_n
);
  logic p_q, p_d, n_q, n_d;

  // Level is high while the carrier is below the duty; muted low when idle
  always_comb begin
    p_d = run && ({1'b0, carrier} < duty_p);
    n_d = run && ({1'b0, carrier} < duty_n);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_q <= 1'b0;
      n_q <= 1'b0;
    end else begin
      p_q <= p_d;
      n_q <= n_d;
    end
  end

  assign out_p = p_q;
  assign out_n = n_q;
endmodule

// [logic/apf_dc_timer.sv]
// Persistence timer for one channel's DC imbalance
`timescale 1ns/1ps
module apf_dc_timer
  import apf_pkg::*;
#(
  parameter int PERSIST_CYC = DC_PERSIST_CYC
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Observed imbalance
  input  wire logic                  active,
  input  wire logic signed [PWM_BITS:0] dev,
  // Persistence reached
  output logic                       trip
);
  logic [31:0] cnt_q, cnt_d;
  logic        pol_q, pol_d;
  logic        trip_q, trip_d;
  logic        over;
  logic        pol_now;
  logic [PWM_BITS:0] mag;

  // Differential duty is twice the deviation; compare it in percent
  always_comb begin
    mag     = dev[PWM_BITS] ? (~dev + 1'b1) : dev;
    pol_now = ~dev[PWM_BITS];
    over    = (32'(mag) * 32'd200) > (32'(DC_PCT) * 32'(PWM_PERIOD));
    cnt_d   = cnt_q;
    pol_d   = pol_q;
    trip_d  = 1'b0;
    if (!active || !over || (pol_now != pol_q)) begin
      cnt_d = 32'h0;
      pol_d = pol_now;
    end else if (cnt_q >= 32'(PERSIST_CYC)) begin
      trip_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 32'h0;
      pol_q  <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      pol_q  <= pol_d;
      trip_q <= trip_d;
    end
  end

  assign trip = trip_q;
endmodule

// [logic/apf_top.sv]
// Protection, power limit, bridge mode and fault control of a stereo class-D stage
//
// Behaviour
// - Shutdown pin low mutes both bridges and stops the carrier.
// - Duty deviation is capped at four times the power limit level.
// - Same-polarity imbalance over 14 percent for 420 ms raises DC fault.
// - Gain scaling makes the DC input threshold fall as gain rises.
// - DC fault pulls fault pin low and releases all bridge outputs.
// - DC fault stays latched until reset; shutdown pin does not clear it.
// - Parallel bridge mode drives both sides of each bridge in phase from right input.
// - Parallel bridge select low gives two independent stereo bridges.
// - Overcurrent sets short latch, pulls fault low, releases all outputs.
// - Shutdown pin passing through low clears the short latch.
// - Die above 150 C stops outputs, resumes once 15 C cooler, no latch.
// - Thermal shutdown never shows on the fault pin.
// - Two gain select pins pick 20, 26, 32 or 36 dB.
// - Zero input switches both sides in phase; signal splits duties around half.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module apf_top
  import apf_pkg::*;
#(
  parameter int DC_PERSIST = apf_pkg::DC_PERSIST_CYC
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // Control pins
  input  wire logic                          shutdown_n_input,
  input  wire logic                          parallel_bridge_select,
  input  wire logic                          gain_select_lsb,
  input  wire logic                          gain_select_msb,
  // Sense inputs: overcurrent per output {rn, rp, ln, lp}, die temperature
  input  wire logic [3:0]                    overcurrent,
  input  wire logic [7:0]                    die_temp_c,
  // Audio samples, same clock
  input  wire logic signed [SAMPLE_BITS-1:0] sample_left,
  input  wire logic signed [SAMPLE_BITS-1:0] sample_right,
  // Bridge outputs, index 0 left, 1 right
  output logic [1:0]                         bridge_out_positive,
  output logic [1:0]                         bridge_out_positive_oe,
  output logic [1:0]                         bridge_out_negative,
  output logic [1:0]                         bridge_out_negative_oe,
  // Open-drain fault pin
  output logic                               fault_n_o,
  output logic                               fault_n_oe
);
  typedef logic signed [PWM_BITS:0] apf_dev_t;

  // Gain multiplier, then cap at the virtual rail
  function automatic apf_dev_t apf_scale(input logic signed [SAMPLE_BITS-1:0] s,
                                         input logic [1:0] g,
                                         input logic [7:0] lim);
    logic signed [SAMPLE_BITS+3:0] prod;
    logic signed [SAMPLE_BITS+3:0] sh;
    logic signed [SAMPLE_BITS+3:0] cap;
    logic [9:0]                    rail;
    prod = '0;
    case (g)
      2'b00:   prod = 20'(s);
      2'b01:   prod = 20'(s) <<< 1;
      2'b10:   prod = 20'(s) <<< 2;
      default: prod = (20'(s) <<< 2) + (20'(s) <<< 1);
    endcase
    sh   = prod >>> (SAMPLE_BITS - PWM_BITS);
    rail = 10'(LIMIT_SCALE) * {2'b00, lim};
    cap  = (rail > 10'(PWM_HALF)) ? 20'(PWM_HALF) : 20'(rail);
    if (sh > cap) begin
      sh = cap;
    end else if (sh < -cap) begin
      sh = -cap;
    end
    return apf_dev_t'(sh[PWM_BITS:0]);
  endfunction

  // Three-stage pin synchroniser with agreement filter
  logic [SY_W-1:0] sy1_q, sy2_q, sy3_q, syf_q, syf_d;
  logic [SY_W-1:0] pins;

  assign pins = {overcurrent, gain_select_msb, gain_select_lsb,
                 parallel_bridge_select, shutdown_n_input};

  always_comb begin
    syf_d = syf_q;
    for (int i = 0; i < SY_W; i++) begin
      if (sy2_q[i] == sy3_q[i]) begin
        syf_d[i] = sy3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      syf_q <= '0;
    end else begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      syf_q <= syf_d;
    end
  end

  logic       shdn_n;
  logic       par_mode;
  logic [1:0] gain;
  logic       oc_any;

  assign shdn_n = syf_q[SY_SHDN];
  assign par_mode = syf_q[SY_PAR];
  assign gain   = {syf_q[SY_G1], syf_q[SY_G0]};
  assign oc_any = |syf_q[SY_OC +: 4];

  // Software registers
  logic [7:0] limit_q, limit_d;
  logic       auto_q, auto_d;

  // Protection latches and run state
  logic dc_q, dc_d;
  logic short_q, short_d;
  logic therm_q, therm_d;
  logic run_q, run_d;
  logic [1:0] dc_trip;

  // Latches: set wins over clear
  always_comb begin
    dc_d    = dc_q | (|dc_trip);
    short_d = short_q;
    if (oc_any) begin
      short_d = 1'b1;
    end else if (!shdn_n || (auto_q && short_q)) begin
      short_d = 1'b0;
    end
    if (therm_q) begin
      therm_d = die_temp_c > (TEMP_TRIP_C - TEMP_HYST_C);
    end else begin
      therm_d = die_temp_c > TEMP_TRIP_C;
    end
    run_d = shdn_n && !dc_d && !short_d && !therm_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q    <= 1'b0;
      short_q <= 1'b0;
      therm_q <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      dc_q    <= dc_d;
      short_q <= short_d;
      therm_q <= therm_d;
      run_q   <= run_d;
    end
  end

  // Carrier counter, held at zero while idle
  logic [PWM_BITS-1:0] carrier_q, carrier_d;

  always_comb begin
    carrier_d = run_q ? carrier_q + 1'b1 : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_q <= '0;
    end else begin
      carrier_q <= carrier_d;
    end
  end

  // Deviations and duties for both bridges
  apf_dev_t            dev_l, dev_r;
  logic [PWM_BITS:0]   dp_l, dn_l, dp_r, dn_r;

  always_comb begin
    dev_r = apf_scale(sample_right, gain, limit_q);
    if (par_mode) begin
      dev_l = -dev_r;
      dp_l  = PWM_HALF + 9'(dev_l);
      dn_l  = dp_l;
      dp_r  = PWM_HALF + 9'(dev_r);
      dn_r  = dp_r;
    end else begin
      dev_l = apf_scale(sample_left, gain, limit_q);
      dp_l  = PWM_HALF + 9'(dev_l);
      dn_l  = PWM_HALF - 9'(dev_l);
      dp_r  = PWM_HALF + 9'(dev_r);
      dn_r  = PWM_HALF - 9'(dev_r);
    end
  end

  logic [1:0] lvl_p, lvl_n;

  apf_pwm_bridge u_bridge_l (
    .pclk    (pclk),
    .presetn (presetn),
    .carrier (carrier_q),
    .run     (run_q),
    .duty_p  (dp_l),
    .duty_n  (dn_l),
    .out_p   (lvl_p[0]),
    .out_n   (lvl_n[0])
  );

  apf_pwm_bridge u_bridge_r (
    .pclk    (pclk),
    .presetn (presetn),
    .carrier (carrier_q),
    .run     (run_q),
    .duty_p  (dp_r),
    .duty_n  (dn_r),
    .out_p   (lvl_p[1]),
    .out_n   (lvl_n[1])
  );

  // DC watch only while running; in parallel mode the bridge sides agree and only the right watch stays on
  logic dc_active;
  assign dc_active = run_q && !par_mode;

  apf_dc_timer #(.PERSIST_CYC(DC_PERSIST)) u_dc_l (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (dc_active),
    .dev     (dev_l),
    .trip    (dc_trip[0])
  );

  apf_dc_timer #(.PERSIST_CYC(DC_PERSIST)) u_dc_r (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (run_q),
    .dev     (dev_r),
    .trip    (dc_trip[1])
  );

  // Output enables and fault pin
  logic [1:0] oe_q, oe_d;
  logic       fault_q, fault_d;

  always_comb begin
    oe_d    = {2{run_q}};
    fault_d = dc_q | short_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q    <= 2'b00;
      fault_q <= 1'b0;
    end else begin
      oe_q    <= oe_d;
      fault_q <= fault_d;
    end
  end

  // APB slave, answer in the first access cycle
  logic        rdy_q, rdy_d;
  logic [31:0] rd_q, rd_d;
  logic        err_q, err_d;
  logic        fault_lo_q;
  logic        wr_go;
  logic [31:0] status;

  assign wr_go = psel && penable && rdy_q && pwrite;

  always_comb begin
    status              = 32'h0;
    status[ST_DC]       = dc_q;
    status[ST_SHORT]    = short_q;
    status[ST_THERM]    = therm_q;
    status[ST_SHDN_N]   = shdn_n;
    status[ST_PAR]      = par_mode;
    status[ST_GAIN +: 2] = gain;
    status[ST_RUN]      = run_q;
  end

  always_comb begin
    rdy_d   = psel && !penable;
    rd_d    = rd_q;
    err_d   = 1'b0;
    limit_d = limit_q;
    auto_d  = auto_q;
    if (psel && !penable) begin
      rd_d = 32'h0;
      if (paddr == ADDR_LIMIT) begin
        rd_d = {24'h0, limit_q};
      end else if (paddr == ADDR_CTRL) begin
        rd_d = {31'h0, auto_q};
      end else if (paddr == ADDR_STATUS) begin
        rd_d = status;
      end else begin
        err_d = 1'b1;
      end
      if (pwrite) begin
        rd_d = 32'h0;
      end
    end else if (penable) begin
      err_d = err_q;
    end
    if (wr_go) begin
      if (paddr == ADDR_LIMIT) begin
        limit_d = pwdata[7:0];
      end else if (paddr == ADDR_CTRL) begin
        auto_d = pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q      <= 1'b0;
      rd_q       <= 32'h0;
      err_q      <= 1'b0;
      limit_q    <= LIMIT_RST;
      auto_q     <= CTRL_RST;
      fault_lo_q <= 1'b0;
    end else begin
      rdy_q      <= rdy_d;
      rd_q       <= rd_d;
      err_q      <= err_d;
      limit_q    <= limit_d;
      auto_q     <= auto_d;
      fault_lo_q <= 1'b0;
    end
  end

  assign pready                 = rdy_q;
  assign prdata                 = rd_q;
  assign pslverr                = err_q;
  assign bridge_out_positive    = lvl_p;
  assign bridge_out_negative    = lvl_n;
  assign bridge_out_positive_oe = oe_q;
  assign bridge_out_negative_oe = oe_q;
  assign fault_n_o              = fault_lo_q;
  assign fault_n_oe             = fault_q;
endmodule

// [test/apf_top_sva.sv]
// Checker of pin, bridge and fault behaviour, bound to the top
`timescale 1ns/1ps
module apf_top_sva
  import apf_pkg::*;
#(
  parameter int DC_PERSIST = 50
) (
  // Clock, reset and bus
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pready,
  // Pins and sense
  input wire logic                          shutdown_n_input,
  input wire logic                          parallel_bridge_select,
  input wire logic [3:0]                    overcurrent,
  input wire logic [7:0]                    die_temp_c,
  input wire logic signed [SAMPLE_BITS-1:0] sample_left,
  input wire logic signed [SAMPLE_BITS-1:0] sample_right,
  // Bridges and fault
  input wire logic [1:0]                    bridge_out_positive,
  input wire logic [1:0]                    bridge_out_positive_oe,
  input wire logic [1:0]                    bridge_out_negative,
  input wire logic [1:0]                    bridge_out_negative_oe,
  input wire logic                          fault_n_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic all_off;
  // All four bridge sides released
  assign all_off = (bridge_out_positive_oe == 2'b00) && (bridge_out_negative_oe == 2'b00);

  property p_shdn_mute;
    !shutdown_n_input [*7] |-> all_off;
  endproperty
  a_shdn_mute: assert property (p_shdn_mute)
    else $error("bridges still driven during shutdown");
  property p_run_after_shdn;
    $rose(bridge_out_positive_oe[0]) |-> $past(shutdown_n_input, 4);
  endproperty
  a_run_after_shdn: assert property (p_run_after_shdn)
    else $error("bridge enabled without shutdown pin high");
  property p_fault_release;
    fault_n_oe && $past(fault_n_oe) |-> all_off;
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("bridges driven while fault shown");
  property p_short_flag;
    (overcurrent != 4'h0) [*3] |-> ##[0:5] fault_n_oe;
  endproperty
  a_short_flag: assert property (p_short_flag)
    else $error("overcurrent not shown on fault pin");
  property p_hot_off;
    (die_temp_c > TEMP_TRIP_C) [*6] |-> all_off;
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("bridges driven above trip temperature");
  property p_hot_quiet;
    ((die_temp_c > TEMP_TRIP_C) && (overcurrent == 4'h0)) [*8] |-> !$rose(fault_n_oe);
  endproperty
  a_hot_quiet: assert property (p_hot_quiet)
    else $error("thermal stop shown on fault pin");
  property p_par_phase;
    parallel_bridge_select [*8] |-> bridge_out_positive == bridge_out_negative;
  endproperty
  a_par_phase: assert property (p_par_phase)
    else $error("parallel mode sides not in phase");
  property p_zero_phase;
    ((sample_left == 16'h0000) && (sample_right == 16'h0000)) [*8]
      |-> bridge_out_positive == bridge_out_negative;
  endproperty
  a_zero_phase: assert property (p_zero_phase)
    else $error("zero input sides not in phase");
  property p_apb_wait;
    psel && !penable |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("bus answer not in first access cycle");
  // Main scenarios reached
  c_short: cover property ($rose(fault_n_oe));
  c_par: cover property (parallel_bridge_select && !all_off);
  c_hot: cover property ((die_temp_c > TEMP_TRIP_C) && all_off);
endmodule

bind apf_top apf_top_sva #(.DC_PERSIST(DC_PERSIST)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .shutdown_n_input(shutdown_n_input), .parallel_bridge_select(parallel_bridge_select),
  .overcurrent(overcurrent), .die_temp_c(die_temp_c), .sample_left(sample_left),
  .sample_right(sample_right), .bridge_out_positive(bridge_out_positive),
  .bridge_out_positive_oe(bridge_out_positive_oe),
  .bridge_out_negative(bridge_out_negative),
  .bridge_out_negative_oe(bridge_out_negative_oe), .fault_n_oe(fault_n_oe)
);

// [test/apf_speaker_model.sv]
// Speaker load model reporting overcurrent on commanded shorts
`timescale 1ns/1ps
module apf_speaker_model (
  // Bridge enables, index 0 left, 1 right
  input  wire logic [1:0] oe_p,
  input  wire logic [1:0] oe_n,
  // Shorts to inject, {rn, rp, ln, lp}
  input  wire logic [3:0] short_cmd,
  // Overcurrent sense back to the block
  output logic      [3:0] overcurrent
);
  // Shorted side draws current only while its bridge drives it
  assign overcurrent = short_cmd & {oe_n[1], oe_p[1], oe_n[0], oe_p[0]};
endmodule

// [test/amp_protection_fault_control_bench.sv]
// Self-checking bench for the amplifier protection top
`timescale 1ns/1ps
module amp_protection_fault_control_bench;
  import apf_pkg::*;
  localparam int PERSIST = 1000;
  logic                          pclk = 1'b0;
  logic                          presetn = 1'b0;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [7:0]                    paddr = 8'h00;
  logic [31:0]                   pwdata = 32'h0;
  logic                          pready;
  logic [31:0]                   prdata;
  logic                          pslverr;
  logic                          shdn_drv = 1'b0;
  logic                          tie = 1'b0;
  logic                          par_sel = 1'b0;
  logic [1:0]                    gain = 2'b00;
  logic [3:0]                    short_cmd = 4'h0;
  logic [3:0]                    overcurrent;
  logic [7:0]                    temp = 8'h19;
  logic signed [SAMPLE_BITS-1:0] s_l = '0;
  logic signed [SAMPLE_BITS-1:0] s_r = '0;
  logic [1:0]                    op;
  logic [1:0]                    op_oe;
  logic [1:0]                    on;
  logic [1:0]                    on_oe;
  logic                          f_o;
  logic                          f_oe;
  logic                          fault_wire;
  logic                          shdn;
  logic [31:0]                   rd;
  logic                          err;
  int                            fails = 0;
  int                            checks = 0;
  int                            cnt [4];

  always #2 pclk = ~pclk;
  // Open-drain fault line with pull-up, optionally tied to shutdown
  assign fault_wire = f_oe ? f_o : 1'b1;
  assign shdn = tie ? fault_wire : shdn_drv;

  apf_top #(
    .DC_PERSIST(PERSIST)
  ) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .shutdown_n_input(shdn),
    .parallel_bridge_select(par_sel), .gain_select_lsb(gain[0]),
    .gain_select_msb(gain[1]), .overcurrent(overcurrent), .die_temp_c(temp),
    .sample_left(s_l), .sample_right(s_r), .bridge_out_positive(op),
    .bridge_out_positive_oe(op_oe), .bridge_out_negative(on),
    .bridge_out_negative_oe(on_oe), .fault_n_o(f_o), .fault_n_oe(f_oe)
  );
  apf_speaker_model u_spk (
    .oe_p(op_oe), .oe_n(on_oe), .short_cmd(short_cmd), .overcurrent(overcurrent)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic st(input logic [3:0] e, input logic f);
    chk("bridge_oe", {28'h0, e}, {28'h0, op_oe, on_oe});
    chk("fault_oe", {31'h0, f}, {31'h0, f_oe});
    chk("fault_pin", {31'h0, ~f}, {31'h0, fault_wire});
  endtask
  // High cycles per side over one carrier period
  task automatic duty();
    cnt = '{0, 0, 0, 0};
    repeat (256) begin
      @(negedge pclk);
      for (int i = 0; i < 2; i++) begin
        cnt[i] += int'(op[i]);
        cnt[i+2] += int'(on[i]);
      end
    end
    // Back to the rising edge before any input changes
    @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    cyc(20000);
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    cyc(20);
    presetn <= 1'b1;
    rdchk("limit_rst", ADDR_LIMIT, {24'h0, LIMIT_RST}, 32'hffffffff);
    rdchk("ctrl_rst", ADDR_CTRL, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CTRL, 32'h1);
    rdchk("ctrl_rw", ADDR_CTRL, 32'h1, 32'hffffffff);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_LIMIT, 32'h8);
    rdchk("limit_rw", ADDR_LIMIT, 32'h8, 32'hffffffff);
    shdn_drv <= 1'b1;
    cyc(20);
    st(4'hf, 1'b0);
    duty();
    chk("zero_p", 32'h80, cnt[0]);
    chk("zero_n", 32'h80, cnt[2]);
    for (int g = 0; g < 4; g++) begin
      gain <= g[1:0];
      cyc(10);
      rdchk("gain_code", ADDR_STATUS, {25'h0, g[1:0], 5'h0}, 32'h60);
    end
    s_l <= 16'sh4000;
    cyc(20);
    duty();
    chk("limit_p", 32'ha0, cnt[0]);
    chk("limit_n", 32'h60, cnt[2]);
    chk("other_p", 32'h80, cnt[1]);
    s_l <= '0;
    gain <= 2'b00;
    par_sel <= 1'b1;
    s_r <= 16'sh0a00;
    cyc(20);
    duty();
    chk("par_right", 32'h8a, cnt[1]);
    chk("par_left", 32'h76, cnt[0]);
    par_sel <= 1'b0;
    s_r <= '0;
    temp <= 8'h97;
    cyc(10);
    st(4'h0, 1'b0);
    rdchk("therm", ADDR_STATUS, 32'h4, 32'h4);
    temp <= 8'h8c;
    cyc(10);
    st(4'h0, 1'b0);
    temp <= 8'h87;
    cyc(20);
    st(4'hf, 1'b0);
    short_cmd <= 4'h1;
    cyc(20);
    st(4'h0, 1'b1);
    rdchk("short", ADDR_STATUS, 32'h2, 32'h2);
    short_cmd <= 4'h0;
    cyc(20);
    st(4'h0, 1'b1);
    shdn_drv <= 1'b0;
    cyc(10);
    shdn_drv <= 1'b1;
    cyc(20);
    st(4'hf, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    short_cmd <= 4'h2;
    cyc(8);
    st(4'h0, 1'b1);
    cyc(4);
    short_cmd <= 4'h0;
    cyc(30);
    st(4'hf, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    tie <= 1'b1;
    short_cmd <= 4'h8;
    cyc(12);
    short_cmd <= 4'h0;
    cyc(40);
    st(4'hf, 1'b0);
    tie <= 1'b0;
    s_l <= 16'sh1100;
    cyc(1100);
    st(4'hf, 1'b0);
    s_l <= 16'sh1200;
    cyc(600);
    s_l <= -16'sh1200;
    cyc(600);
    st(4'hf, 1'b0);
    s_l <= 16'sh1200;
    cyc(1100);
    st(4'h0, 1'b1);
    s_l <= '0;
    shdn_drv <= 1'b0;
    cyc(10);
    shdn_drv <= 1'b1;
    cyc(20);
    st(4'h0, 1'b1);
    rdchk("dc", ADDR_STATUS, 32'h1, 32'h1);
    presetn <= 1'b0;
    shdn_drv <= 1'b0;
    cyc(20);
    presetn <= 1'b1;
    cyc(5);
    shdn_drv <= 1'b1;
    cyc(20);
    st(4'hf, 1'b0);
    tally_and_finish();
  end
endmodule
